// [verilog/gpio_dir_pkg.sv]
package gpio_dir_pkg;
    // pin count and register split
    localparam int PIN_COUNT = 24;
    localparam int LOW_PINS = 16;
    // register word indices as printed (not multiples of four)
    localparam logic [11:0] IDX_DIR_LOW = 12'h300;
    localparam logic [11:0] IDX_DIR_HIGH = 12'h302;
    localparam logic [11:0] IDX_INEN_LOW = 12'h304;
    localparam logic [11:0] IDX_INEN_HIGH = 12'h306;
    // pin state register, chosen index
    localparam logic [11:0] IDX_PIN_STATE_LOW = 12'h30c;
    localparam logic [11:0] IDX_PIN_STATE_HIGH = 12'h30e;
    // byte address width of the slave
    localparam int ADDR_W = 14;
    // reset values
    localparam logic [23:0] RST_DIR = 24'h000000;
    localparam logic [23:0] RST_INEN = 24'h000000;
    localparam logic [23:0] RST_PIN_OUT = 24'h000000;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [verilog/gpio_pin_cell.sv]
`timescale 1ns/1ps
// one pin: output drive and gated input sampling
module gpio_pin_cell (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_dir_out,
    input wire logic i_in_en,
    input wire logic i_out_val,
    input wire logic i_pin_level,
    output logic o_pin_oe,
    output logic o_pin_out,
    output logic o_sampled
);
    // state of the cell
    typedef struct packed {
        logic oe;
        logic out;
        logic smp;
    } cell_t;
    cell_t st;
    cell_t next_st;

    // next-state logic
    always_comb begin
        next_st = st;
        next_st.oe = i_dir_out;
        next_st.out = i_out_val;
        // disabled input reads as zero, not the live pin
        next_st.smp = i_in_en ? i_pin_level : 1'b0;
        if (i_sys_rst) begin
            next_st = '0;
        end
    end

    // state register
    always_ff @(posedge i_clk) begin
        st <= next_st;
    end

    assign o_pin_oe = st.oe;
    assign o_pin_out = st.out;
    assign o_sampled = st.smp;
endmodule

// [verilog/gpio_direction_input_enable.sv]
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
// Functional notes
// - 24 direction bits, zero means input
// - direction one drives pin as output
// - pins 0-15 low, 16-23 high register
// - per-pin input enable, reset disabled
// - input enables split low and high
// - output pins follow state; inputs read back
module gpio_direction_input_enable #(
    parameter int PINS = gpio_dir_pkg::PIN_COUNT
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [gpio_dir_pkg::ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [gpio_dir_pkg::ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic [gpio_dir_pkg::PIN_COUNT-1:0] i_io_pin_x,
    output logic [gpio_dir_pkg::PIN_COUNT-1:0] o_io_pin_x,
    output logic [gpio_dir_pkg::PIN_COUNT-1:0] o_io_pin_x_oe
);
    import gpio_dir_pkg::*;

    // the register split is fixed at 16 plus 8 pins;
    // other counts would need new register slots, so refuse them at elaboration
    if (PINS != PIN_COUNT) begin : g_bad_pins
        $error("only 24 pins are supported");
    end

    // whole slave state
    // one struct keeps the bus side and the pin registers in a single flop bank
    typedef struct packed {
        logic aw_held;                  // write address taken
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;                   // write data taken
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [23:0] dir;               // 1 = output
        logic [23:0] inen;              // 1 = input sensing on
        logic [23:0] pout;              // pin state written by software
        logic awready;                  // registered write-address ready
        logic wready;                   // registered write-data ready
        logic arready;                  // registered read-address ready
    } regs_t;
    regs_t st;
    regs_t next_st;

    logic [23:0] sampled;               // gated pin levels from cells
    logic [11:0] wr_idx;
    logic [11:0] rd_idx;
    logic [23:0] state_view;

    // word index = byte address / 4
    assign wr_idx = st.aw_addr[ADDR_W-1:2];
    assign rd_idx = i_araddr[ADDR_W-1:2];
    // outputs read back driven value, inputs the gated level;
    // an output pin reads its written state at once, its pad follows an edge later
    assign state_view = (st.dir & st.pout) | (~st.dir & sampled);

    // per-pin cells
    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : g_pin
            // each cell registers drive, enable and sample, so the pads see flops
            // and the input level is taken once before anything reads it
            gpio_pin_cell u_cell (
                .i_clk(i_clk),
                .i_sys_rst(i_sys_rst),
                .i_dir_out(st.dir[g]),
                .i_in_en(st.inen[g]),
                .i_out_val(st.pout[g]),
                .i_pin_level(i_io_pin_x[g]),
                .o_pin_oe(o_io_pin_x_oe[g]),
                .o_pin_out(o_io_pin_x[g]),
                .o_sampled(sampled[g])
            );
        end
    endgenerate

    // merge a 16-bit write under byte strobes
    // lanes 2 and 3 carry nothing: no register here is wider than 16 bits
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        logic [15:0] r;
        r = old;
        if (s[0]) begin
            r[7:0] = d[7:0];
        end
        if (s[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    // bus handshakes and register updates
    always_comb begin
        logic [15:0] tmp;
        tmp = '0;
        next_st = st;
        // accept address and data independently, one write at a time
        // nothing is taken while the answer of the last write still waits
        if (i_awvalid && !st.aw_held && !st.bvalid) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = i_awaddr;
        end
        if (i_wvalid && !st.w_held && !st.bvalid) begin
            next_st.w_held = 1'b1;
            next_st.w_data = i_wdata;
            next_st.w_strb = i_wstrb;
        end
        // both halves present: commit and respond
        if (st.aw_held && st.w_held) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_OKAY;
            // decode the word index; holes answer with an error and nothing lands
            case (wr_idx)
                IDX_DIR_LOW: begin
                    next_st.dir[15:0] = merge16(st.dir[15:0], st.w_data, st.w_strb);
                end
                IDX_DIR_HIGH: begin
                    // upper byte unused, only low lane lands
                    tmp = merge16({8'h00, st.dir[23:16]}, st.w_data, st.w_strb);
                    next_st.dir[23:16] = tmp[7:0];
                end
                IDX_INEN_LOW: begin
                    next_st.inen[15:0] = merge16(st.inen[15:0], st.w_data, st.w_strb);
                end
                IDX_INEN_HIGH: begin
                    // same lane rule as the high direction register
                    tmp = merge16({8'h00, st.inen[23:16]}, st.w_data, st.w_strb);
                    next_st.inen[23:16] = tmp[7:0];
                end
                IDX_PIN_STATE_LOW: begin
                    next_st.pout[15:0] = merge16(st.pout[15:0], st.w_data, st.w_strb);
                end
                IDX_PIN_STATE_HIGH: begin
                    tmp = merge16({8'h00, st.pout[23:16]}, st.w_data, st.w_strb);
                    next_st.pout[23:16] = tmp[7:0];
                end
                default: begin
                    next_st.bresp = RESP_SLVERR; // unmapped write
                end
            endcase
        end
        // write answer stands until the master takes it
        if (st.bvalid && i_bready) begin
            next_st.bvalid = 1'b0;
        end
        // reads: one outstanding, answered the cycle after acceptance
        if (st.rvalid && i_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (i_arvalid && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            // data come from the current state: a write committed on this edge
            // shows in a read taken on the next one
            // high registers: only pins 16-23 exist, bits 15-8 read as zero
            case (rd_idx)
                IDX_DIR_LOW: next_st.rdata = {16'h0000, st.dir[15:0]};
                IDX_DIR_HIGH: next_st.rdata = {24'h000000, st.dir[23:16]};
                IDX_INEN_LOW: next_st.rdata = {16'h0000, st.inen[15:0]};
                IDX_INEN_HIGH: next_st.rdata = {24'h000000, st.inen[23:16]};
                IDX_PIN_STATE_LOW: next_st.rdata = {16'h0000, state_view[15:0]};
                IDX_PIN_STATE_HIGH: next_st.rdata = {24'h000000, state_view[23:16]};
                default: begin
                    next_st.rdata = 32'h00000000;
                    next_st.rresp = RESP_SLVERR;
                end
            endcase
        end
        // synchronous reset: all pins input, inputs disabled
        // reset wins over any handshake in the same cycle
        if (i_sys_rst) begin
            next_st = '0;
            next_st.dir = RST_DIR;
            next_st.inen = RST_INEN;
            next_st.pout = RST_PIN_OUT;
        end
        // readies come from the next state so that every bus output is a flop;
        // the edges on which halves are taken stay the same
        // a held half or an unanswered write keeps its ready low
        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready = !next_st.w_held && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;
    end

    // single state register
    // no clock enable: every bit of state moves on every edge
    always_ff @(posedge i_clk) begin
        st <= next_st;
    end

    // every bus output is read straight from the state register
    assign o_awready = st.awready;
    assign o_wready = st.wready;
    assign o_arready = st.arready;
    assign o_bvalid = st.bvalid;
    assign o_bresp = st.bresp;
    assign o_rvalid = st.rvalid;
    assign o_rdata = st.rdata;
    assign o_rresp = st.rresp;
endmodule

// [verif/gpio_pins_model.sv]
`timescale 1ns/1ps
// outside circuitry: the device drives where enabled, else the outside level wins
module gpio_pins_model (
    input wire logic [23:0] i_oe,
    input wire logic [23:0] i_out,
    input wire logic [23:0] i_ext,
    output logic [23:0] o_level
);
    // wired level per pin, no contention modelled
    assign o_level = (i_oe & i_out) | (~i_oe & i_ext);
endmodule

// [verif/gpio_dir_sva.sv]
`timescale 1ns/1ps
// bus answers and pin outputs against their causes
module gpio_dir_sva (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [13:0] i_araddr,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic o_bvalid,
    input wire logic [23:0] i_io_pin_x,
    input wire logic [23:0] o_io_pin_x,
    input wire logic [23:0] o_io_pin_x_oe
);
    logic [13:0] ra; // address of the read in flight
    always_ff @(posedge i_clk) if (i_arvalid && o_arready) ra <= i_araddr;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    AST_RST_IDLE: assert property ($fell(i_sys_rst) |-> o_io_pin_x_oe == 0 && o_io_pin_x == 0)
        else $error("pins not idle after reset");
    AST_OE_BY_WRITE: assert property (!$stable(o_io_pin_x_oe) |-> $past(o_bvalid))
        else $error("direction moved without a write");
    AST_OUT_BY_WRITE: assert property (!$stable(o_io_pin_x) |-> $past(o_bvalid))
        else $error("drive moved without a write");
    AST_HIGH_BYTE: assert property ($rose(o_rvalid) && ra[3] |-> o_rdata[31:8] == 0)
        else $error("high register shows bits above 7");
    AST_LOW_HALF: assert property ($rose(o_rvalid) |-> o_rdata[31:16] == 0)
        else $error("read shows bits above 15");
    AST_OUT_READ: assert property ($rose(o_rvalid) && ra == 14'hc30 |->
        ((o_rdata[15:0] ^ o_io_pin_x[15:0]) & o_io_pin_x_oe[15:0]) == 0)
        else $error("output pin reads wrong state");
    AST_IN_LOW: assert property ($rose(o_rvalid) && ra == 14'hc30 |->
        (o_rdata[15:0] & ~o_io_pin_x_oe[15:0] & ~$past(i_io_pin_x[15:0], 2)) == 0)
        else $error("low input pin reads high");
    AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read answer dropped");
endmodule
bind gpio_direction_input_enable gpio_dir_sva gpio_dir_sva_inst (.i_clk, .i_sys_rst,
    .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rvalid, .i_rready, .o_bvalid,
    .i_io_pin_x, .o_io_pin_x, .o_io_pin_x_oe);

// [verif/tb_gpio_direction_input_enable.sv]
`timescale 1ns/1ps
module tb_gpio_direction_input_enable;
    logic i_clk = 0, i_sys_rst = 1, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
    logic i_arvalid = 0, i_rready = 0, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [13:0] i_awaddr = 0, i_araddr = 0;
    logic [31:0] i_wdata = 0, o_rdata, rd_val;
    logic [3:0] i_wstrb = 4'hf;
    logic [1:0] o_bresp, o_rresp, resp;
    logic [23:0] i_io_pin_x, o_io_pin_x, o_io_pin_x_oe, ext = 24'hffffff;
    logic ha, hw, hb;
    int error_cnt = 0, n_compared = 0, rlag = 0; // rlag: edges before rready rises
    gpio_direction_input_enable gpio_direction_input_enable_inst (.i_clk, .i_sys_rst,
        .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready,
        .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
        .o_rresp, .o_rvalid, .i_rready, .i_io_pin_x, .o_io_pin_x, .o_io_pin_x_oe);
    gpio_pins_model gpio_pins_model_inst (.i_oe(o_io_pin_x_oe), .i_out(o_io_pin_x),
        .i_ext(ext), .o_level(i_io_pin_x));
    initial forever #4 i_clk = ~i_clk;
    task finish_test;
        if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // handshakes judged at the falling edge, released after the next rising one;
    // registered outputs hold still from the falling edge to the rising one
    task wr(input logic [13:0] a, input logic [31:0] d);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1;
        i_wvalid <= 1;
        i_bready <= 1; // stays high, so it is never lowered and raised in one step
        do begin
            @(negedge i_clk);
            ha = i_awvalid && o_awready;
            hw = i_wvalid && o_wready;
            hb = o_bvalid && i_bready;
            resp = o_bresp;
            @(posedge i_clk);
            if (ha) i_awvalid <= 0;
            if (hw) i_wvalid <= 0;
        end while (!hb);
    endtask
    // read; rready rises rlag edges after the request, at once when rlag is zero
    task rd(input logic [13:0] a);
        int n;
        n = 0;
        i_araddr <= a;
        i_arvalid <= 1;
        i_rready <= (rlag == 0);
        do begin
            @(negedge i_clk);
            ha = i_arvalid && o_arready;
            hb = o_rvalid && i_rready;
            rd_val = o_rdata;
            resp = o_rresp;
            @(posedge i_clk);
            if (ha) i_arvalid <= 0;
            n++;
            if (n == rlag) i_rready <= 1;
        end while (!hb);
    endtask
    task t_reset; // direction and input-enable registers clear, pins released
        rd(14'hc00);
        chk("dir_low", 0, rd_val);
        rd(14'hc08);
        chk("dir_high", 0, rd_val);
        rd(14'hc10);
        chk("inen_low", 0, rd_val);
        rd(14'hc18);
        chk("inen_high", 0, rd_val);
        @(negedge i_clk);
        chk("oe", 0, {8'h00, o_io_pin_x_oe});
        @(posedge i_clk);
    endtask
    task t_dir; // mixed directions, high register drops its upper byte
        wr(14'hc00, 32'h0000a5c3);
        wr(14'hc08, 32'hffffff5a);
        wr(14'hc30, 32'h0000ffff);
        wr(14'hc38, 32'h000000ff);
        rd(14'hc08);
        chk("dir_high", 32'h5a, rd_val);
        rd(14'hc00);
        chk("dir_low", 32'ha5c3, rd_val);
        @(negedge i_clk);
        chk("oe", 32'h5aa5c3, {8'h00, o_io_pin_x_oe});
        chk("drive", 32'h5aa5c3, {8'h00, o_io_pin_x & o_io_pin_x_oe});
        @(posedge i_clk);
    endtask
    task t_inen; // inputs read zero until software enables them
        rd(14'hc30);
        chk("state_off", 32'ha5c3, rd_val);
        wr(14'hc10, 32'h0000ffff);
        wr(14'hc18, 32'h000000ff);
        rd(14'hc18);
        chk("inen_high", 32'hff, rd_val);
        rd(14'hc10);
        chk("inen_low", 32'hffff, rd_val);
        rd(14'hc30);
        chk("state_on", 32'hffff, rd_val);
        rd(14'hc38);
        chk("state_hi_on", 32'hff, rd_val);
        ext <= 0;
        repeat (3) @(posedge i_clk);
        rd(14'hc30);
        chk("state_lo_low", 32'ha5c3, rd_val);
        rd(14'hc38);
        chk("state_hi_low", 32'h5a, rd_val);
    endtask
    task t_rd_stall; // read answer must stand while the master holds rready low
        rlag = 3;
        rd(14'hc08);
        rlag = 0;
        chk("dir_high_late", 32'h5a, rd_val);
    endtask
    task t_unmapped; // holes answer with an error and zero data
        rd(14'hc04);
        chk("rresp", 2'h2, resp);
        chk("rdata", 0, rd_val);
        wr(14'hc20, 32'h1);
        chk("bresp", 2'h2, resp);
    endtask
    // reset for ten cycles, then the scenarios in order
    initial begin
        repeat (10) @(posedge i_clk);
        i_sys_rst <= 0;
        @(posedge i_clk);
        t_reset;
        t_dir;
        t_inen;
        t_rd_stall;
        t_unmapped;
        finish_test;
    end
    // watchdog against a hung handshake; the scenarios need under a hundred cycles
    initial begin
        repeat (5000) @(posedge i_clk);
        error_cnt++;
        finish_test;
    end
endmodule
